// [shared/hsp_pkg.sv]
/*
 shared constants for the four-pin programming port: the switch end and the far end.
 assumes a 100 MHz core clock and a far party built as plain logic on the same kind of clock.
*/
// Operation
// - strap high selects slave, low selects rom master
// - host serial clock never above 2 MHz
// - slave works only while select held low
// - control, address, write data captured from inbound pin
// - slave drives read data on outbound pin
// - rom mode: switch drives serial clock out
// - rom mode: active-high chip select for reads
// - rom mode: commands and address on inbound pin
// - rom mode: rom data received on outbound pin
package hsp_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CORE_HZ      = 100_000_000;
	localparam int SCK_MAX_HZ   = 2_000_000;
	// least half period, rounded up to whole cycles
	localparam int SCK_HALF_CYC = (CORE_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ);
	localparam int STRAP_SETTLE = 3;

	// ----------------------------------------
	// frame layout
	// ----------------------------------------
	localparam int       FRAME_BITS    = 24;
	localparam int       CMD_LAST_BIT  = 7;
	localparam int       ADDR_LAST_BIT = 15;
	localparam int       DATA_LAST_BIT = 23;
	localparam logic [7:0] CMD_READ    = 8'h80;
	localparam logic [7:0] CMD_WRITE   = 8'h00;
	localparam logic [2:0] ROM_READ_OP = 3'h6;
	localparam int       ROM_HDR_BITS  = 11;
	localparam int       ROM_DATA_BITS = 8;

	// ----------------------------------------
	// reset values and roles
	// ----------------------------------------
	localparam logic ROLE_HOST   = 1'b1;
	localparam logic ROLE_ROM    = 1'b0;
	localparam logic RST_SCK     = 1'b0;
	localparam logic RST_SEL_N   = 1'b1;
	localparam logic RST_DATA    = 1'b1;
	localparam logic PULL_SCK    = 1'b0;
	localparam logic PULL_OTHERS = 1'b1;
endpackage

// [shared/hsp_pins_if.sv]
/*
 the four shared pins between the switch end and the far end.
 assumes each end drives a pin only while its enable is high; pulls fill the rest.
*/
`timescale 1ns/1ns
interface hsp_pins_if;
	logic dev_sck_o, dev_sck_oe, dev_sel_o, dev_sel_oe;
	logic dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe;
	logic far_sck_o, far_sck_oe, far_sel_o, far_sel_oe;
	logic far_mosi_o, far_mosi_oe, far_miso_o, far_miso_oe;
	logic sck, sel, mosi, miso;

	// ----------------------------------------
	// wire levels
	// ----------------------------------------
	assign sck  = dev_sck_oe ? dev_sck_o : (far_sck_oe ? far_sck_o : hsp_pkg::PULL_SCK);
	assign sel  = dev_sel_oe ? dev_sel_o : (far_sel_oe ? far_sel_o : hsp_pkg::PULL_OTHERS);
	assign mosi = dev_mosi_oe ? dev_mosi_o : (far_mosi_oe ? far_mosi_o : hsp_pkg::PULL_OTHERS);
	assign miso = dev_miso_oe ? dev_miso_o : (far_miso_oe ? far_miso_o : hsp_pkg::PULL_OTHERS);

	modport dev (
		output dev_sck_o, dev_sck_oe, dev_sel_o, dev_sel_oe,
		output dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe,
		input  sck, sel, mosi, miso
	);
	modport far (
		output far_sck_o, far_sck_oe, far_sel_o, far_sel_oe,
		output far_mosi_o, far_mosi_oe, far_miso_o, far_miso_oe,
		input  sck, sel, mosi, miso
	);
endinterface

// [rtl/hsp_port_device.sv]
/*
 switch end of the programming port: spi slave onto a small register file, or rom loader.
 assumes the role strap is steady around reset release and the far end keeps its timing.
*/
`timescale 1ns/1ns
module hsp_port_device #(
	parameter int REG_COUNT = 16,
	parameter int CFG_BYTES = 16
) (
	input  wire logic       core_clk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       clk_en_in,
	input  wire logic       host_or_rom_role_strap_in,
	hsp_pins_if.dev         pins,
	input  wire logic [7:0] user_addr_in,
	output logic [7:0]      user_rdata_out,
	output logic            role_host_out,
	output logic            role_valid_out,
	output logic            load_done_out
);
	localparam int AW = $clog2(REG_COUNT);
	localparam int SCK = 0, SEL = 1, MOSI = 2, MISO = 3, STRAP = 4;
	// pin stages start at the pull levels so no false edge follows reset; the strap stage starts at 0
	localparam logic [4:0] PIN_IDLE = {1'b0, hsp_pkg::PULL_OTHERS, hsp_pkg::PULL_OTHERS, hsp_pkg::PULL_OTHERS,
	                                   hsp_pkg::PULL_SCK};

	typedef enum logic [3:0] {
		E_IDLE = 4'h1,
		E_SEND = 4'h2,
		E_RECV = 4'h4,
		E_GAP  = 4'h8
	} hsp_rom_state_type;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [4:0] s1_ff, s2_ff, s3_ff, lvl_ff;
	wire  [4:0] raw_w = {host_or_rom_role_strap_in, pins.miso, pins.mosi, pins.sel, pins.sck};
	wire  [4:0] agree_w = ~(s2_ff ^ s3_ff);
	wire  [4:0] nxt_lvl = (agree_w & s2_ff) | (~agree_w & lvl_ff);
	wire  [4:0] rise_w = nxt_lvl & ~lvl_ff;
	wire  [4:0] fall_w = ~nxt_lvl & lvl_ff;

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s1_ff  <= PIN_IDLE;
			s2_ff  <= PIN_IDLE;
			s3_ff  <= PIN_IDLE;
			lvl_ff <= PIN_IDLE;
		end else if (clk_en_in) begin
			s1_ff  <= raw_w;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			lvl_ff <= nxt_lvl;
		end
	end

	// ----------------------------------------
	// role strap
	// ----------------------------------------
	logic [1:0] settle_ff;
	logic       role_ff, valid_ff;
	wire        settled_w = (settle_ff == 2'(hsp_pkg::STRAP_SETTLE));

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			settle_ff <= 2'h0;
			role_ff   <= hsp_pkg::ROLE_ROM;
			valid_ff  <= 1'b0;
		end else if (clk_en_in && !valid_ff) begin
			if (!settled_w) begin
				settle_ff <= settle_ff + 2'h1;
			end else if (agree_w[STRAP]) begin
				role_ff  <= s2_ff[STRAP];
				valid_ff <= 1'b1;
			end
		end
	end

	wire host_w = valid_ff && (role_ff == hsp_pkg::ROLE_HOST);
	wire rom_w  = valid_ff && (role_ff == hsp_pkg::ROLE_ROM);

	// ----------------------------------------
	// spi slave decode
	// ----------------------------------------
	logic [4:0]    bit_ff;
	logic [7:0]    sh_ff, out_ff;
	logic [AW-1:0] addr_ff;
	logic          rd_ff, miso_ff;
	logic [7:0]    regs [REG_COUNT];
	// nothing moves unless select is low
	wire           sel_w    = host_w && !lvl_ff[SEL];
	wire           srise_w  = sel_w && rise_w[SCK];
	wire           sfall_w  = sel_w && fall_w[SCK];
	wire [7:0]     byte_w   = {sh_ff[6:0], lvl_ff[MOSI]};
	wire           wr_hit_w = srise_w && !rd_ff && (bit_ff == 5'(hsp_pkg::DATA_LAST_BIT));
	wire           out_go_w = sfall_w && rd_ff && (bit_ff >= 5'(hsp_pkg::ADDR_LAST_BIT + 1))
	                          && (bit_ff <= 5'(hsp_pkg::DATA_LAST_BIT));
	wire [AW-1:0]  uaddr_w  = user_addr_in[AW-1:0];

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			bit_ff  <= 5'h0;
			sh_ff   <= 8'h0;
			rd_ff   <= 1'b0;
			addr_ff <= '0;
		end else if (clk_en_in) begin
			if (!sel_w) begin
				bit_ff <= 5'h0;
				// a stale read flag would drive the outbound pin early
				rd_ff  <= 1'b0;
			end else if (srise_w) begin
				sh_ff  <= byte_w;
				bit_ff <= bit_ff + 5'h1;
				if (bit_ff == 5'(hsp_pkg::CMD_LAST_BIT))
					rd_ff <= sh_ff[6];
				if (bit_ff == 5'(hsp_pkg::ADDR_LAST_BIT))
					addr_ff <= byte_w[AW-1:0];
			end
		end
	end

	// read data out on falling edges
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			out_ff  <= 8'h0;
			miso_ff <= hsp_pkg::RST_DATA;
		end else if (clk_en_in && out_go_w) begin
			if (bit_ff == 5'(hsp_pkg::ADDR_LAST_BIT + 1)) begin
				out_ff  <= {regs[addr_ff][6:0], 1'b0};
				miso_ff <= regs[addr_ff][7];
			end else begin
				out_ff  <= {out_ff[6:0], 1'b0};
				miso_ff <= out_ff[7];
			end
		end
	end

	// ----------------------------------------
	// rom loader
	// ----------------------------------------
	hsp_rom_state_type st_ff;
	logic [5:0]  div_ff;
	logic [3:0]  cnt_ff;
	logic [7:0]  idx_ff, rx_ff;
	logic [10:0] tx_ff;
	logic        sck_ff, cs_ff, done_ff;
	wire         tick_w  = (div_ff == 6'(hsp_pkg::SCK_HALF_CYC - 1));
	wire         busy_w  = (st_ff == E_SEND) || (st_ff == E_RECV);
	wire         start_w = rom_w && !done_ff && (st_ff == E_IDLE);
	wire         up_w    = busy_w && tick_w && !sck_ff;
	wire         dn_w    = busy_w && tick_w && sck_ff;
	wire         hdr_end = (cnt_ff == 4'(hsp_pkg::ROM_HDR_BITS - 1));
	wire         dat_end = (cnt_ff == 4'(hsp_pkg::ROM_DATA_BITS - 1));
	wire         store_w = dn_w && (st_ff == E_RECV) && dat_end;
	wire         last_w  = (idx_ff == 8'(CFG_BYTES - 1));

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_ff   <= E_IDLE;
			div_ff  <= 6'h0;
			cnt_ff  <= 4'h0;
			idx_ff  <= 8'h0;
			rx_ff   <= 8'h0;
			tx_ff   <= 11'h0;
			sck_ff  <= hsp_pkg::RST_SCK;
			cs_ff   <= 1'b0;
			done_ff <= 1'b0;
		end else if (clk_en_in) begin
			div_ff <= (tick_w || st_ff == E_IDLE) ? 6'h0 : div_ff + 6'h1;
			if (up_w || dn_w)
				sck_ff <= ~sck_ff;
			unique case (st_ff)
				E_IDLE: if (start_w) begin
					cs_ff  <= 1'b1;
					tx_ff  <= {hsp_pkg::ROM_READ_OP, idx_ff};
					cnt_ff <= 4'h0;
					st_ff  <= E_SEND;
				end
				E_SEND: if (dn_w) begin
					tx_ff  <= {tx_ff[9:0], 1'b0};
					cnt_ff <= hdr_end ? 4'h0 : cnt_ff + 4'h1;
					if (hdr_end)
						st_ff <= E_RECV;
				end
				E_RECV: begin
					if (up_w)
						rx_ff <= {rx_ff[6:0], lvl_ff[MISO]};
					if (dn_w) begin
						cnt_ff <= cnt_ff + 4'h1;
						if (dat_end) begin
							cs_ff <= 1'b0;
							st_ff <= E_GAP;
						end
					end
				end
				E_GAP: if (tick_w) begin
					// gap keeps select low long enough for the far filter
					idx_ff  <= idx_ff + 8'h1;
					done_ff <= last_w;
					st_ff   <= E_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// register file
	// ----------------------------------------
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < REG_COUNT; i++)
				regs[i] <= 8'h0;
		end else if (clk_en_in) begin
			if (wr_hit_w)
				regs[addr_ff] <= byte_w;
			else if (store_w && (idx_ff < 8'(REG_COUNT)))
				regs[idx_ff[AW-1:0]] <= rx_ff;
		end
	end

	// ----------------------------------------
	// pins and user outputs
	// ----------------------------------------
	logic [7:0] urd_ff;
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			urd_ff <= 8'h0;
		else if (clk_en_in)
			urd_ff <= regs[uaddr_w];
	end

	assign user_rdata_out   = urd_ff;
	assign role_host_out    = role_ff;
	assign role_valid_out   = valid_ff;
	assign load_done_out    = done_ff;
	assign pins.dev_sck_o   = sck_ff;
	assign pins.dev_sck_oe  = rom_w;
	assign pins.dev_sel_o   = cs_ff;
	assign pins.dev_sel_oe  = rom_w;
	assign pins.dev_mosi_o  = tx_ff[10];
	assign pins.dev_mosi_oe = rom_w;
	assign pins.dev_miso_o  = miso_ff;
	assign pins.dev_miso_oe = sel_w && rd_ff;
endmodule

// [rtl/hsp_port_far.sv]
/*
 far end of the programming port: spi master for register access, or a serial rom.
 assumes role_in matches the strap given to the switch end and stays fixed after reset.
*/
`timescale 1ns/1ns
module hsp_port_far #(
	parameter int MEM_DEPTH = 256
) (
	input  wire logic       core_clk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       clk_en_in,
	input  wire logic       role_in,
	hsp_pins_if.far         pins,
	input  wire logic       req_in,
	input  wire logic       write_in,
	input  wire logic [7:0] addr_in,
	input  wire logic [7:0] wdata_in,
	output logic            busy_out,
	output logic            done_out,
	output logic [7:0]      rdata_out,
	input  wire logic       mem_we_in,
	input  wire logic [7:0] mem_addr_in,
	input  wire logic [7:0] mem_wdata_in
);
	localparam int SCK = 0, SEL = 1, MOSI = 2, MISO = 3;
	// stages start at the pull levels so no false edge follows reset
	localparam logic [3:0] PIN_IDLE = {hsp_pkg::PULL_OTHERS, hsp_pkg::PULL_OTHERS, hsp_pkg::PULL_OTHERS,
	                                   hsp_pkg::PULL_SCK};

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	logic [3:0] s1_ff, s2_ff, s3_ff, lvl_ff;
	wire  [3:0] agree_w = ~(s2_ff ^ s3_ff);
	wire  [3:0] nxt_lvl = (agree_w & s2_ff) | (~agree_w & lvl_ff);
	wire  [3:0] rise_w  = nxt_lvl & ~lvl_ff;
	wire  [3:0] fall_w  = ~nxt_lvl & lvl_ff;

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s1_ff  <= PIN_IDLE;
			s2_ff  <= PIN_IDLE;
			s3_ff  <= PIN_IDLE;
			lvl_ff <= PIN_IDLE;
		end else if (clk_en_in) begin
			s1_ff  <= {pins.miso, pins.mosi, pins.sel, pins.sck};
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			lvl_ff <= nxt_lvl;
		end
	end

	// ----------------------------------------
	// spi master
	// ----------------------------------------
	logic [5:0]  div_ff;
	logic [4:0]  bit_ff;
	logic [23:0] tx_ff;
	logic [7:0]  rx_ff, rd_ff;
	logic        run_ff, sck_ff, ss_n_ff, done_ff;
	wire         host_w = (role_in == hsp_pkg::ROLE_HOST);
	wire         tick_w = (div_ff == 6'(hsp_pkg::SCK_HALF_CYC - 1));
	wire         last_w = (bit_ff == 5'(hsp_pkg::FRAME_BITS - 1));
	wire [7:0]   cmd_w  = write_in ? hsp_pkg::CMD_WRITE : hsp_pkg::CMD_READ;

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			div_ff  <= 6'h0;
			bit_ff  <= 5'h0;
			tx_ff   <= 24'h0;
			rx_ff   <= 8'h0;
			rd_ff   <= 8'h0;
			run_ff  <= 1'b0;
			sck_ff  <= hsp_pkg::RST_SCK;
			ss_n_ff <= hsp_pkg::RST_SEL_N;
			done_ff <= 1'b0;
		end else if (clk_en_in) begin
			done_ff <= 1'b0;
			div_ff  <= (tick_w || !run_ff) ? 6'h0 : div_ff + 6'h1;
			if (!run_ff && req_in && host_w) begin
				run_ff  <= 1'b1;
				ss_n_ff <= 1'b0;
				bit_ff  <= 5'h0;
				tx_ff   <= {cmd_w, addr_in, wdata_in};
			end else if (run_ff && tick_w) begin
				// half period keeps clock at 2 MHz
				sck_ff <= ~sck_ff;
				if (!sck_ff) begin
					rx_ff <= {rx_ff[6:0], lvl_ff[MISO]};
				end else begin
					tx_ff  <= {tx_ff[22:0], 1'b0};
					bit_ff <= bit_ff + 5'h1;
					if (last_w) begin
						run_ff  <= 1'b0;
						ss_n_ff <= 1'b1;
						rd_ff   <= rx_ff;
						done_ff <= 1'b1;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// serial rom
	// ----------------------------------------
	logic [7:0] mem [MEM_DEPTH];
	logic [4:0] rcnt_ff;
	logic [7:0] radr_ff, rout_ff;
	logic       do_ff;
	wire        cs_w   = !host_w && lvl_ff[SEL];
	wire        hdr_w  = rcnt_ff < 5'(hsp_pkg::ROM_HDR_BITS);
	wire [7:0]  nadr_w = {radr_ff[6:0], lvl_ff[MOSI]};
	wire        drv_w  = cs_w && fall_w[SCK] && !hdr_w
	                     && (rcnt_ff < 5'(hsp_pkg::ROM_HDR_BITS + hsp_pkg::ROM_DATA_BITS));

	always_ff @(posedge core_clk_in) begin
		if (clk_en_in && mem_we_in)
			mem[mem_addr_in] <= mem_wdata_in;
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rcnt_ff <= 5'h0;
			radr_ff <= 8'h0;
			rout_ff <= 8'h0;
			do_ff   <= hsp_pkg::RST_DATA;
		end else if (clk_en_in) begin
			if (!cs_w) begin
				rcnt_ff <= 5'h0;
			end else if (rise_w[SCK] && hdr_w) begin
				radr_ff <= nadr_w;
				rcnt_ff <= rcnt_ff + 5'h1;
				if (rcnt_ff == 5'(hsp_pkg::ROM_HDR_BITS - 1))
					rout_ff <= mem[nadr_w];
			end else if (drv_w) begin
				do_ff   <= rout_ff[7];
				rout_ff <= {rout_ff[6:0], 1'b0};
				rcnt_ff <= rcnt_ff + 5'h1;
			end
		end
	end

	// ----------------------------------------
	// pins and user outputs
	// ----------------------------------------
	assign busy_out         = run_ff;
	assign done_out         = done_ff;
	assign rdata_out        = rd_ff;
	assign pins.far_sck_o   = sck_ff;
	assign pins.far_sck_oe  = host_w;
	assign pins.far_sel_o   = ss_n_ff;
	assign pins.far_sel_oe  = host_w;
	assign pins.far_mosi_o  = tx_ff[23];
	assign pins.far_mosi_oe = host_w;
	assign pins.far_miso_o  = do_ff;
	assign pins.far_miso_oe = cs_w;
endmodule

// [tb/hsp_pins_properties.sv]
/*
 concurrent checks on the pins joining the switch end and the far end.
 assumes both ends run on core_clk_in and share sys_rst_in.
*/
`timescale 1ns/1ns
module hsp_pins_properties (
	input  wire logic core_clk_in,
	input  wire logic sys_rst_in,
	input  wire logic dev_sck_oe,
	input  wire logic dev_sel_oe,
	input  wire logic dev_mosi_oe,
	input  wire logic dev_miso_oe,
	input  wire logic sck,
	input  wire logic sel,
	input  wire logic mosi,
	input  wire logic miso
);
	localparam int HALF_MIN = hsp_pkg::SCK_HALF_CYC - 1;
	logic [7:0] hold_ff;
	logic [7:0] nxt_hold;
	logic       sck_ff;

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);

	// ----------------------------------------
	// cycles since the link clock last moved
	// ----------------------------------------
	// saturates so an idle link never wraps into a short count
	assign nxt_hold = (sck_ff != sck) ? 8'h00 : ((hold_ff == 8'hff) ? hold_ff : hold_ff + 8'h01);
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			hold_ff <= 8'hff;
			sck_ff  <= 1'b0;
		end else begin
			hold_ff <= nxt_hold;
			sck_ff  <= sck;
		end
	end

	// ----------------------------------------
	// pin checks
	// ----------------------------------------
	no_drive_reset_a: assert property ($fell(sys_rst_in) |-> !dev_sck_oe && !dev_sel_oe && !dev_mosi_oe && !dev_miso_oe)
		else $error("switch end drove a pin at reset release");
	roles_exclusive_a: assert property (!(dev_miso_oe && dev_sck_oe))
		else $error("both roles driving at once");
	rom_pins_out_a: assert property (dev_sck_oe |-> dev_sel_oe && dev_mosi_oe && !dev_miso_oe)
		else $error("rom role pin directions wrong");
	role_fixed_a: assert property (dev_sck_oe |=> dev_sck_oe)
		else $error("rom role dropped its clock drive");
	miso_idle_a: assert property (sel [*8] |-> !dev_miso_oe)
		else $error("outbound pin driven while select high");
	miso_start_a: assert property ($rose(dev_miso_oe) |-> !sel && !dev_sck_oe)
		else $error("outbound drive began outside a selected frame");
	rom_clock_sel_a: assert property (dev_sck_oe && $rose(sck) |-> sel)
		else $error("rom clock edge without chip select");
	mosi_steady_a: assert property ($rose(sck) |-> $stable(mosi))
		else $error("inbound data moved at a rising clock");
	miso_steady_a: assert property ($rose(sck) |-> $stable(miso))
		else $error("outbound data moved at a rising clock");
	sck_half_a: assert property (sck != sck_ff |-> hold_ff >= HALF_MIN)
		else $error("link clock half period too short");
endmodule

// [tb/host_serial_or_eeprom_port_tb_top.sv]
/*
 bench: both ends joined in either role, plus a lone switch end under a rogue driver.
 assumes one 100 MHz clock; far rom array keeps its contents across reset.
*/
`timescale 1ns/1ns
module host_serial_or_eeprom_port_tb_top;
	localparam int CFG = 16;
	logic        core_clk_in = 1'b0;
	logic        sys_rst_in  = 1'b1;
	logic        clk_en      = 1'b1;
	logic        strap       = 1'b1;
	logic        req         = 1'b0;
	logic        wr          = 1'b0;
	logic [7:0]  addr        = 8'h00;
	logic [7:0]  wdata       = 8'h00;
	logic        mem_we      = 1'b0;
	logic [7:0]  mem_addr    = 8'h00;
	logic [7:0]  mem_wdata   = 8'h00;
	logic [7:0]  user_addr   = 8'h00;
	logic        miso_b_seen = 1'b0;
	logic [15:0] seed        = 16'h41ec;
	logic [7:0]  user_rdata, user_rdata_b, rdata, mcap;
	logic        role_host, role_valid, load_done, busy, done;
	logic [7:0]  model [16];
	logic [7:0]  rom_img [16];
	logic [23:0] cap;
	logic [10:0] hdr;
	int          bits, rom_bits;
	int          err_total   = 0;
	int          comparisons = 0;

	always #5 core_clk_in = ~core_clk_in;

	hsp_pins_if pins ();
	hsp_pins_if pins_b ();
	hsp_port_device #(.REG_COUNT(16), .CFG_BYTES(CFG)) u_hsp_port_device (.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in), .clk_en_in(clk_en), .host_or_rom_role_strap_in(strap), .pins(pins),
		.user_addr_in(user_addr), .user_rdata_out(user_rdata), .role_host_out(role_host),
		.role_valid_out(role_valid), .load_done_out(load_done));
	hsp_port_far #(.MEM_DEPTH(256)) u_hsp_port_far (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en), .role_in(strap), .pins(pins), .req_in(req), .write_in(wr), .addr_in(addr),
		.wdata_in(wdata), .busy_out(busy), .done_out(done), .rdata_out(rdata), .mem_we_in(mem_we),
		.mem_addr_in(mem_addr), .mem_wdata_in(mem_wdata));
	hsp_port_device #(.REG_COUNT(16), .CFG_BYTES(CFG)) u_hsp_port_device_b (.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in), .clk_en_in(clk_en), .host_or_rom_role_strap_in(1'b1), .pins(pins_b),
		.user_addr_in(8'h03), .user_rdata_out(user_rdata_b), .role_host_out(), .role_valid_out(),
		.load_done_out());
	hsp_pins_properties u_hsp_pins_properties (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
		.dev_sck_oe(pins.dev_sck_oe), .dev_sel_oe(pins.dev_sel_oe), .dev_mosi_oe(pins.dev_mosi_oe),
		.dev_miso_oe(pins.dev_miso_oe), .sck(pins.sck), .sel(pins.sel), .mosi(pins.mosi), .miso(pins.miso));

	// ----------------------------------------
	// wire monitors
	// ----------------------------------------
	always @(posedge pins.sck) begin
		if (!pins.sel) begin
			cap  = {cap[22:0], pins.mosi};
			mcap = {mcap[6:0], pins.miso};
			bits++;
		end else begin
			hdr = (rom_bits < 11) ? {hdr[9:0], pins.mosi} : hdr;
			rom_bits++;
		end
	end
	always @(posedge core_clk_in) begin
		if (pins_b.dev_miso_oe === 1'b1) begin
			miso_b_seen <= 1'b1;
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// header as the frame layout defines it: command bit then address
	function automatic logic [23:0] exp_hdr(input logic w, input logic [7:0] a);
		logic [7:0] cmd;
		cmd = w ? hsp_pkg::CMD_WRITE : hsp_pkg::CMD_READ;
		return {15'h0, cmd[7], a};
	endfunction

	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic do_reset(input logic role);
		sys_rst_in <= 1'b1;
		strap      <= role;
		rom_bits = 0;
		repeat (5) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		repeat (10) @(posedge core_clk_in);
		@(negedge core_clk_in);
		check("latched role", {22'h0, role, 1'b1}, {22'h0, role_host, role_valid});
	endtask

	task automatic spi_op(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		bits = 0;
		@(posedge core_clk_in);
		req   <= 1'b1;
		wr    <= w;
		addr  <= a;
		wdata <= d;
		@(posedge core_clk_in);
		req <= 1'b0;
		@(negedge core_clk_in);
		check("busy in frame", 24'h1, {23'h0, busy});
		for (n = 0; n < 1400 && done !== 1'b1; n++) @(negedge core_clk_in);
		check("frame done", 24'h1, {23'h0, done});
		check("busy after frame", 24'h0, {23'h0, busy});
		check("frame bit count", 24'h18, bits[23:0]);
		check("inbound header", exp_hdr(w, a), {15'h0, cap[23], cap[15:8]});
		if (w) begin
			model[a[3:0]] = d;
			check("inbound data", {16'h0, d}, {16'h0, cap[7:0]});
		end else begin
			check("read data", {16'h0, model[a[3:0]]}, {16'h0, rdata});
			check("outbound wire", {16'h0, model[a[3:0]]}, {16'h0, mcap});
		end
		repeat (4) @(posedge core_clk_in);
	endtask

	task automatic read_regs(input logic rom);
		for (int i = 0; i < 16; i++) begin
			@(posedge core_clk_in);
			user_addr <= i[7:0];
			@(posedge core_clk_in);
			@(negedge core_clk_in);
			check("register", {16'h0, rom ? rom_img[i] : model[i]}, {16'h0, user_rdata});
		end
	endtask

	// rogue master clocks a write at 80 ns with select left high
	task automatic rogue_frame();
		logic [23:0] f;
		f = {hsp_pkg::CMD_WRITE, 8'h03, 8'ha5};
		for (int i = 23; i >= 0; i--) begin
			pins_b.far_mosi_o <= f[i];
			repeat (4) @(posedge core_clk_in);
			pins_b.far_sck_o <= 1'b1;
			repeat (4) @(posedge core_clk_in);
			pins_b.far_sck_o <= 1'b0;
		end
		repeat (8) @(posedge core_clk_in);
		@(negedge core_clk_in);
		check("write with select high", 24'h0, {16'h0, user_rdata_b});
		check("outbound enable unselected", 24'h0, {23'h0, miso_b_seen});
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		pins_b.far_sck_o   = 1'b0;
		pins_b.far_sck_oe  = 1'b1;
		pins_b.far_sel_o   = 1'b1;
		pins_b.far_sel_oe  = 1'b1;
		pins_b.far_mosi_o  = 1'b1;
		pins_b.far_mosi_oe = 1'b1;
		pins_b.far_miso_o  = 1'b1;
		pins_b.far_miso_oe = 1'b0;
		do_reset(1'b1);
		// rom image loaded now; the array is not cleared by reset
		for (int i = 0; i < 16; i++) begin
			seed = lfsr_next(seed);
			rom_img[i] = seed[7:0];
			model[i] = 8'h00;
			@(posedge core_clk_in);
			mem_we    <= 1'b1;
			mem_addr  <= i[7:0];
			mem_wdata <= seed[7:0];
		end
		@(posedge core_clk_in);
		mem_we <= 1'b0;
		spi_op(1'b1, 8'h0f, 8'hff);
		spi_op(1'b0, 8'h0f, 8'h00);
		spi_op(1'b1, 8'h00, 8'h00);
		spi_op(1'b0, 8'h00, 8'h5a);
		for (int k = 0; k < 10; k++) begin
			seed = lfsr_next(seed);
			spi_op(seed[4], {4'h0, seed[3:0]}, seed[15:8]);
		end
		read_regs(1'b0);
		// both ends frozen mid frame must resume without losing a bit
		fork
			spi_op(1'b0, 8'h0f, 8'h00);
			begin
				repeat (300) @(posedge core_clk_in);
				clk_en <= 1'b0;
				repeat (40) @(posedge core_clk_in);
				clk_en <= 1'b1;
			end
		join
		rogue_frame();
		do_reset(1'b0);
		for (int n = 0; n < 20000 && load_done !== 1'b1; n++) @(negedge core_clk_in);
		check("rom load done", 24'h1, {23'h0, load_done});
		check("rom clock count", 24'(CFG * (hsp_pkg::ROM_HDR_BITS + hsp_pkg::ROM_DATA_BITS)), rom_bits[23:0]);
		check("rom header", {13'h0, hsp_pkg::ROM_READ_OP, 8'h00}, {13'h0, hdr});
		read_regs(1'b1);
		give_verdict();
	end

	initial begin
		#600000;
		err_total++;
		give_verdict();
	end
endmodule
